// [hw/drive_chk_pkg.sv]
package drive_chk_pkg;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned SILENCE_NS = 10000000;
   localparam int unsigned SILENCE_CYCLES = (SILENCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned FIFO_DEPTH = 16;

   // ************************************************************
   // check constants and frame codes
   // ************************************************************
   localparam logic [15:0] CRC_PRESET = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;
   localparam logic [7:0] FUNC_READ = 8'h03;
   localparam logic [7:0] FUNC_WRITE = 8'h06;
   localparam logic [7:0] FUNC_LOOP = 8'h08;
   localparam logic [7:0] BCAST_ADDR = 8'h00;
   localparam logic [7:0] ASCII_START = 8'h3a;
   localparam logic [7:0] ASCII_CR = 8'h0d;
   localparam logic [7:0] ASCII_LF = 8'h0a;

   // ************************************************************
   // register map and fields
   // ************************************************************
   localparam logic [15:0] REG_RUN_CMD = 16'h2000;
   localparam logic [15:0] REG_FREQ = 16'h2001;
   localparam logic [15:0] REG_FAULT = 16'h2002;
   localparam int unsigned RUN_LSB = 0;
   localparam int unsigned DIR_LSB = 4;
   localparam int unsigned PROF_LSB = 6;
   localparam int unsigned FAULT_EXT_BIT = 0;
   localparam int unsigned FAULT_RST_BIT = 1;
   localparam logic [15:0] FREQ_RESET = 16'h0000;

   typedef enum logic [1:0] {
      RUN_NONE = 2'b00,
      RUN_STOP = 2'b01,
      RUN_GO = 2'b10,
      RUN_JOG = 2'b11
   } run_action_t;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_FIRST = 2'b01,
      TX_SECOND = 2'b10
   } tx_phase_t;

   typedef struct packed {
      logic end_mark;
      logic has_byte;
      logic [7:0] data;
   } token_t;

   localparam int unsigned TOKEN_W = $bits(token_t);

   typedef struct packed {
      run_action_t run;
      logic reverse;
      logic profile2;
      logic [15:0] freq;
      logic ext_fault;
   } drive_cmd_t;

   typedef struct packed {
      logic write;
      logic [7:0] param_group_byte;
      logic [7:0] param_index_byte;
      logic [15:0] data;
   } param_req_t;

   // ************************************************************
   // shared decoding
   // ************************************************************
   function automatic logic [15:0] crc_fold(input logic [15:0] acc, input logic [7:0] b);
      logic [15:0] c;
      c = acc ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

   function automatic logic [4:0] hex_val(input logic [7:0] ch);
      if (ch >= 8'h30 && ch <= 8'h39) begin
         return {1'b1, ch[3:0]};
      end else if (ch >= 8'h41 && ch <= 8'h46) begin
         return {1'b1, 4'(ch[3:0] + 4'h9)};
      end
      return 5'h00;
   endfunction

   function automatic logic [7:0] hex_char(input logic [3:0] n);
      return (n < 4'ha) ? {4'h3, n} : {4'h4, 4'(n - 4'h9)};
   endfunction

   function automatic logic func_known(input logic [7:0] f);
      return f == FUNC_READ || f == FUNC_WRITE || f == FUNC_LOOP;
   endfunction

endpackage

// [hw/rx_token_fifo.sv]
`timescale 1ns/100ps
`default_nettype none
module rx_token_fifo #(
   parameter int unsigned WIDTH = 10,
   parameter int unsigned DEPTH = 16
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   // depth must be a power of two: pointers wrap naturally
   localparam int unsigned AW = $clog2(DEPTH);
   localparam int unsigned CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [CW-1:0] cnt;
      logic rdy;
      logic ov;
      logic [WIDTH-1:0] od;
   } fifo_state_t;

   fifo_state_t q, d;
   logic wr, rd;

   always_comb begin
      d = q;
      wr = in_valid_i && q.rdy;
      rd = (q.cnt != '0) && (!q.ov || out_ready_i);
      if (out_ready_i && q.ov) begin
         d.ov = 1'b0;
      end
      if (rd) begin
         d.od = q.mem[q.rp];
         d.ov = 1'b1;
         d.rp = q.rp + 1'b1;
      end
      if (wr) begin
         d.mem[q.wp] = in_data_i;
         d.wp = q.wp + 1'b1;
      end
      d.cnt = q.cnt + CW'(wr) - CW'(rd);
      // ready is registered from the next count, so full is exact
      d.rdy = d.cnt != CW'(DEPTH);
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign in_ready_o = q.rdy;
   assign out_valid_o = q.ov;
   assign out_data_o = q.od;
endmodule
`default_nettype wire

// [hw/drive_serial_check.sv]
// Overview of operation
// - ascii check: sum bytes address through data mod 256, then negate
// - rtu check accumulator preset to all ones before a message's first byte
// - each byte is xored into the accumulator's low byte
// - shift right zero-filling; if a one dropped out, xor the polynomial
// - exactly eight shift steps per byte before the next byte
// - repeat over all bytes; the final accumulator is the check value
// - rtu check is sent low byte first, then high byte
// - parameter address: high byte is group, low byte is index
// - command bits 1:0 pick none, stop, run, jog plus run
// - command bits 5:4 pick none, forward, reverse, toggle direction
// - command bits 7:6 force first or second accel/decel profile
// - fault word bit 0 external fault, bit 1 drive reset
// - function codes: 03 read, 06 single write, 08 loop test
// - rtu frames are bounded by silences longer than 10 ms
// - ascii check travels as two hex characters, high nibble first
// - address zero is broadcast: acted on, never answered
`timescale 1ns/100ps
`default_nettype none
module drive_serial_check #(
   parameter int unsigned SILENCE_CYCLES = drive_chk_pkg::SILENCE_CYCLES,
   parameter int unsigned FIFO_DEPTH = drive_chk_pkg::FIFO_DEPTH
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ascii_mode_i,
   input wire logic [7:0] motor_drive_station_i,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_data_i,
   output logic rx_ready_o,
   input wire logic tx_start_i,
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   input wire logic tx_end_i,
   output logic tx_chk_valid_o,
   output logic [7:0] tx_chk_byte_o,
   input wire logic reply_ack_i,
   output logic reply_req_o,
   output drive_chk_pkg::drive_cmd_t cmd_o,
   output logic cmd_strobe_o,
   output logic drive_reset_o,
   output logic frame_ok_o,
   output logic frame_bad_o,
   output drive_chk_pkg::param_req_t param_o,
   output logic param_strobe_o
);
   import drive_chk_pkg::*;
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [31:0] sil_cnt;
      logic line_busy;
      logic end_pend;
      logic in_frame;
      logic nib_have;
      logic [3:0] nib_hi;
      logic hex_err;
      logic [15:0] crc;
      logic [7:0] lrc;
      logic [4:0] cnt;
      logic [5:0][7:0] fr;
      logic reply_pend;
      drive_cmd_t cmd;
      logic cmd_stb;
      logic rst_pls;
      logic ok;
      logic bad;
      logic pstb;
      param_req_t par;
      logic [15:0] tcrc;
      logic [7:0] tlrc;
      tx_phase_t tph;
      logic tval;
      logic [7:0] tbyte;
   } state_t;

   state_t q, d;
   token_t push_tok, pop_tok;
   logic fifo_in_rdy, fifo_out_valid, pop;
   logic byte_take, send_end, is_cr, end_now, good, for_us, full6, accept;
   logic wr_cmd, fault_wr, rd_one, byte_v;
   logic [7:0] byte_b, lrc_neg, tcrc_lo, tcrc_hi;
   logic [4:0] chk_len, hv;
   logic [15:0] reg_addr, wr_word;
   logic [1:0] run_field, dir_field, prof_field;
   logic [3:0] lrc_neg_hi, lrc_neg_lo;

   // ************************************************************
   // receive buffer
   // ************************************************************
   // intake stalls while a reply is owed, so a burst really fills it
   rx_token_fifo #(
      .WIDTH(TOKEN_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .in_valid_i(byte_take || send_end),
      .in_data_i(push_tok),
      .in_ready_o(fifo_in_rdy),
      .out_valid_o(fifo_out_valid),
      .out_data_o(pop_tok),
      .out_ready_i(!q.reply_pend)
   );

   // frame fields, decoded from the stored first six bytes
   assign reg_addr = {q.fr[2], q.fr[3]};
   assign wr_word = {q.fr[4], q.fr[5]};
   // only the defined fields are read; reserved bits fall away
   assign run_field = wr_word[RUN_LSB+:2];
   assign dir_field = wr_word[DIR_LSB+:2];
   assign prof_field = wr_word[PROF_LSB+:2];
   assign tcrc_lo = q.tcrc[7:0];
   assign tcrc_hi = q.tcrc[15:8];
   assign lrc_neg = 8'h00 - q.tlrc;
   assign lrc_neg_hi = lrc_neg[7:4];
   assign lrc_neg_lo = lrc_neg[3:0];

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      d = q;
      d.cmd_stb = 1'b0;
      d.rst_pls = 1'b0;
      d.ok = 1'b0;
      d.bad = 1'b0;
      d.pstb = 1'b0;
      d.tval = 1'b0;
      hv = 5'h00;
      byte_v = 1'b0;
      byte_b = 8'h00;
      // line silence: an end marker rides ahead of the next byte
      byte_take = rx_valid_i && fifo_in_rdy;
      send_end = q.end_pend && fifo_in_rdy && !ascii_mode_i;
      push_tok.end_mark = send_end;
      push_tok.has_byte = byte_take;
      push_tok.data = rx_data_i;
      if (send_end) begin
         d.end_pend = 1'b0;
      end
      if (byte_take) begin
         d.sil_cnt = 32'h0;
         d.line_busy = 1'b1;
      end else if (q.line_busy) begin
         if (q.sil_cnt >= 32'(SILENCE_CYCLES - 1)) begin
            d.line_busy = 1'b0;
            d.end_pend = !ascii_mode_i;
         end else begin
            d.sil_cnt = q.sil_cnt + 32'h1;
         end
      end
      // frame end and its decode
      pop = fifo_out_valid && !q.reply_pend;
      is_cr = ascii_mode_i && pop_tok.has_byte && pop_tok.data == ASCII_CR;
      end_now = pop && q.in_frame && ((pop_tok.end_mark && !ascii_mode_i) || is_cr);
      if (reply_ack_i) begin
         d.reply_pend = 1'b0;
      end
      chk_len = ascii_mode_i ? 5'd1 : 5'd2;
      // the check over data plus carried check comes out zero when it matches
      if (ascii_mode_i) begin
         good = q.lrc == 8'h00 && !q.hex_err && !q.nib_have;
      end else begin
         good = q.crc == 16'h0000;
      end
      good = good && q.cnt >= chk_len + 5'd2;
      for_us = q.fr[0] == motor_drive_station_i || q.fr[0] == BCAST_ADDR;
      full6 = q.cnt == 5'd6 + chk_len;
      accept = end_now && good && for_us;
      wr_cmd = accept && q.fr[1] == FUNC_WRITE && full6;
      fault_wr = wr_cmd && reg_addr == REG_FAULT;
      rd_one = accept && q.fr[1] == FUNC_READ && full6 && wr_word == 16'h0001;
      if (end_now) begin
         d.in_frame = 1'b0;
         if (!good) begin
            d.bad = 1'b1;
         end else if (for_us) begin
            d.ok = 1'b1;
            if (q.fr[0] != BCAST_ADDR && func_known(q.fr[1])) begin
               d.reply_pend = 1'b1;
            end
         end
      end
      if (wr_cmd) begin
         if (reg_addr == REG_RUN_CMD) begin
            d.cmd_stb = 1'b1;
            if (run_field != RUN_NONE) begin
               d.cmd.run = run_action_t'(run_field);
            end
            case (dir_field)
               2'b00: begin
               end
               2'b01: d.cmd.reverse = 1'b0;
               2'b10: d.cmd.reverse = 1'b1;
               2'b11: d.cmd.reverse = !q.cmd.reverse;
            endcase
            if (prof_field == 2'b00) begin
               d.cmd.profile2 = 1'b0;
            end else if (prof_field == 2'b01) begin
               d.cmd.profile2 = 1'b1;
            end
         end else if (reg_addr == REG_FREQ) begin
            d.cmd.freq = wr_word;
         end else if (fault_wr) begin
            d.cmd.ext_fault = wr_word[FAULT_EXT_BIT];
            d.rst_pls = wr_word[FAULT_RST_BIT];
         end
      end
      if (rd_one || (wr_cmd && reg_addr != REG_RUN_CMD && reg_addr != REG_FREQ && !fault_wr)) begin
         d.pstb = 1'b1;
         d.par.write = wr_cmd;
         d.par.param_group_byte = q.fr[2];
         d.par.param_index_byte = q.fr[3];
         d.par.data = wr_word;
      end
      // incoming characters and bytes
      if (pop && pop_tok.has_byte) begin
         if (ascii_mode_i) begin
            if (pop_tok.data == ASCII_START) begin
               d.in_frame = 1'b1;
               d.cnt = 5'd0;
               d.lrc = 8'h00;
               d.nib_have = 1'b0;
               d.hex_err = 1'b0;
            end else if (d.in_frame && pop_tok.data != ASCII_LF) begin
               hv = hex_val(pop_tok.data);
               if (!hv[4]) begin
                  d.hex_err = 1'b1;
               end else if (!d.nib_have) begin
                  d.nib_hi = hv[3:0];
                  d.nib_have = 1'b1;
               end else begin
                  byte_v = 1'b1;
                  byte_b = {d.nib_hi, hv[3:0]};
                  d.nib_have = 1'b0;
               end
            end
         end else begin
            if (!d.in_frame) begin
               d.in_frame = 1'b1;
               d.crc = CRC_PRESET;
               d.cnt = 5'd0;
            end
            byte_v = 1'b1;
            byte_b = pop_tok.data;
         end
      end
      if (byte_v) begin
         d.crc = crc_fold(d.crc, byte_b);
         d.lrc = d.lrc + byte_b;
         if (d.cnt < 5'd6) begin
            d.fr[d.cnt[2:0]] = byte_b;
         end
         if (d.cnt != 5'h1f) begin
            d.cnt = d.cnt + 5'h1;
         end
      end
      // reply check generation
      if (tx_start_i) begin
         d.tcrc = CRC_PRESET;
         d.tlrc = 8'h00;
      end
      if (tx_valid_i) begin
         d.tcrc = crc_fold(d.tcrc, tx_data_i);
         d.tlrc = d.tlrc + tx_data_i;
      end
      unique case (q.tph)
         TX_IDLE: begin
            if (tx_end_i) begin
               d.tph = TX_FIRST;
            end
         end
         TX_FIRST: begin
            d.tval = 1'b1;
            d.tbyte = ascii_mode_i ? hex_char(lrc_neg_hi) : tcrc_lo;
            d.tph = TX_SECOND;
         end
         TX_SECOND: begin
            d.tval = 1'b1;
            d.tbyte = ascii_mode_i ? hex_char(lrc_neg_lo) : tcrc_hi;
            d.tph = TX_IDLE;
         end
         default: d.tph = TX_IDLE;
      endcase
   end
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign rx_ready_o = fifo_in_rdy;
   assign tx_chk_valid_o = q.tval;
   assign tx_chk_byte_o = q.tbyte;
   assign reply_req_o = q.reply_pend;
   assign cmd_o = q.cmd;
   assign cmd_strobe_o = q.cmd_stb;
   assign drive_reset_o = q.rst_pls;
   assign frame_ok_o = q.ok;
   assign frame_bad_o = q.bad;
   assign param_o = q.par;
   assign param_strobe_o = q.pstb;

   // ************************************************************
   // assertions
   // ************************************************************
   property p_rtu_preset;
      $rose(q.in_frame) && !ascii_mode_i |-> q.cnt == 5'd1 &&
         q.crc == crc_fold(16'hffff, $past(pop_tok.data));
   endproperty
   a_rtu_preset: assert property (p_rtu_preset) else $error("crc not preset");
   property p_lrc_good;
      q.ok && ascii_mode_i |-> $past(q.lrc) == 8'h00;
   endproperty
   a_lrc_good: assert property (p_lrc_good) else $error("lrc frame accepted with bad sum");
   property p_bad_silent;
      q.bad |-> !q.ok && !q.cmd_stb && !q.rst_pls && !q.pstb && q.cmd == $past(q.cmd);
   endproperty
   a_bad_silent: assert property (p_bad_silent) else $error("bad frame acted on");
   property p_bcast_quiet;
      q.ok && q.fr[0] == 8'h00 |-> !q.reply_pend;
   endproperty
   a_bcast_quiet: assert property (p_bcast_quiet) else $error("broadcast answered");
   property p_run_field;
      q.cmd_stb && $past(run_field) != 2'b00 |-> q.cmd.run == run_action_t'($past(run_field));
   endproperty
   a_run_field: assert property (p_run_field) else $error("run action mismatch");
   property p_dir_toggle;
      q.cmd_stb && $past(dir_field) == 2'b11 |-> q.cmd.reverse != $past(q.cmd.reverse);
   endproperty
   a_dir_toggle: assert property (p_dir_toggle) else $error("direction not toggled");
   property p_profile;
      q.cmd_stb && $past(prof_field) == 2'b01 |-> q.cmd.profile2;
   endproperty
   a_profile: assert property (p_profile) else $error("second profile not forced");
   property p_fault_rst;
      q.rst_pls |-> $past(fault_wr) && $past(wr_word[1]) ##1 !q.rst_pls;
   endproperty
   a_fault_rst: assert property (p_fault_rst) else $error("reset pulse without cause");
   property p_crc_order;
      q.tph == TX_FIRST && !ascii_mode_i |=> tx_chk_valid_o && tx_chk_byte_o == $past(tcrc_lo)
         ##1 tx_chk_valid_o && tx_chk_byte_o == $past(tcrc_hi, 2);
   endproperty
   a_crc_order: assert property (p_crc_order) else $error("crc byte order wrong");
   property p_lrc_chars;
      q.tph == TX_FIRST && ascii_mode_i |=> tx_chk_byte_o == hex_char($past(lrc_neg_hi))
         ##1 tx_chk_byte_o == hex_char($past(lrc_neg_lo, 2));
   endproperty
   a_lrc_chars: assert property (p_lrc_chars) else $error("lrc characters wrong");
   property p_silence;
      $rose(q.end_pend) |-> $past(q.sil_cnt) == 32'(SILENCE_CYCLES - 1) && !ascii_mode_i;
   endproperty
   a_silence: assert property (p_silence) else $error("frame end timing wrong");
endmodule
`default_nettype wire

// [bench/serial_master_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// serial bus master standing at the receive side
// ****************************************
module serial_master_model #(
   parameter int unsigned SIL = 20
) (
   input wire logic mclk_i,
   input wire logic rx_ready_i,
   input wire logic reply_req_i,
   output logic rx_valid_o,
   output logic [7:0] rx_data_o,
   output logic reply_ack_o
);
   int ack_dly = 2;
   int wait_n = 0;
   int stalls = 0;
   initial begin
      rx_valid_o = 1'h0;
      rx_data_o = 8'h00;
      reply_ack_o = 1'h0;
   end
   // ack after a chosen delay; a slow ack keeps intake stalled
   always @(negedge mclk_i) begin
      wait_n = reply_req_i ? wait_n + 1 : 0;
      reply_ack_o <= (wait_n == ack_dly);
   end
   function automatic logic [15:0] crc16(input logic [47:0] f);
      logic [15:0] c;
      c = 16'hffff;
      for (int k = 5; k >= 0; k--) begin
         c = c ^ {8'h00, f[k*8 +: 8]};
         for (int j = 0; j < 8; j++) begin
            c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
         end
      end
      return c;
   endfunction
   function automatic logic [7:0] hx(input logic [3:0] n);
      return (n < 4'ha) ? {4'h3, n} : 8'h37 + {4'h0, n};
   endfunction
   // ready is registered, so its level at the falling edge holds at the next rise
   task automatic put(input logic [7:0] b);
      @(negedge mclk_i);
      rx_valid_o = 1'h1;
      rx_data_o = b;
      while (rx_ready_i !== 1'h1) begin
         stalls++;
         @(negedge mclk_i);
      end
      @(posedge mclk_i);
   endtask
   // released data shows the inverse so a stale byte never looks valid
   task automatic rel();
      @(negedge mclk_i);
      rx_valid_o = 1'h0;
      rx_data_o = ~rx_data_o;
   endtask
   task automatic send_rtu(input logic [47:0] f, input logic [15:0] flip);
      logic [15:0] c;
      c = crc16(f) ^ flip;
      for (int k = 5; k >= 0; k--) begin
         put(f[k*8 +: 8]);
      end
      put(c[7:0]);
      put(c[15:8]);
      rel();
      repeat (SIL + 15) @(negedge mclk_i);
   endtask
   task automatic send_asc(input logic [47:0] f, input logic [7:0] flip);
      logic [7:0] s;
      s = 8'h00;
      put(8'h3a);
      for (int k = 5; k >= 0; k--) begin
         s = s + f[k*8 +: 8];
         put(hx(f[k*8+4 +: 4]));
         put(hx(f[k*8 +: 4]));
      end
      s = (8'h00 - s) ^ flip;
      put(hx(s[7:4]));
      put(hx(s[3:0]));
      put(8'h0d);
      put(8'h0a);
      rel();
   endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import drive_chk_pkg::*;
   localparam int unsigned SIL = 20;
   logic mclk, rst, ascii_mode, rx_valid, rx_ready, tx_start, tx_valid, tx_end, tx_chk_valid;
   logic reply_ack, reply_req, cmd_strobe, drive_reset, frame_ok, frame_bad, param_strobe;
   logic rep_prev;
   logic [7:0] rx_data, tx_data, tx_chk_byte, n_ok, n_bad, n_cmd, n_rst, n_par, n_rep;
   logic [15:0] cap_tx;
   logic [47:0] cnt;
   drive_cmd_t cmd;
   param_req_t param, par_cap;
   int miscompares = 0;
   int tests_run = 0;
   int cyc = 0;
   assign cnt = {n_ok, n_bad, n_cmd, n_rst, n_par, n_rep};
   drive_serial_check #(.SILENCE_CYCLES(SIL), .FIFO_DEPTH(16)) dut_u (.mclk_i(mclk),
      .rst_i(rst), .ascii_mode_i(ascii_mode), .motor_drive_station_i(8'h01),
      .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_ready_o(rx_ready),
      .tx_start_i(tx_start), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_end_i(tx_end),
      .tx_chk_valid_o(tx_chk_valid), .tx_chk_byte_o(tx_chk_byte), .reply_ack_i(reply_ack),
      .reply_req_o(reply_req), .cmd_o(cmd), .cmd_strobe_o(cmd_strobe),
      .drive_reset_o(drive_reset), .frame_ok_o(frame_ok), .frame_bad_o(frame_bad),
      .param_o(param), .param_strobe_o(param_strobe));
   serial_master_model #(.SIL(SIL)) mst_u (.mclk_i(mclk), .rx_ready_i(rx_ready),
      .reply_req_i(reply_req), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
      .reply_ack_o(reply_ack));
   // ****************************************
   // clock, pulse counters and capture
   // ****************************************
   initial begin
      mclk = 1'h0;
      forever #2 mclk = ~mclk;
   end
   // pulses are counted, so a doubled or missing pulse shows in the totals
   always @(posedge mclk) begin
      n_ok <= n_ok + {7'h00, frame_ok};
      n_bad <= n_bad + {7'h00, frame_bad};
      n_cmd <= n_cmd + {7'h00, cmd_strobe};
      n_rst <= n_rst + {7'h00, drive_reset};
      n_par <= n_par + {7'h00, param_strobe};
      n_rep <= n_rep + {7'h00, reply_req & ~rep_prev};
      rep_prev <= reply_req;
      if (param_strobe) begin
         par_cap <= param;
      end
      if (tx_chk_valid) begin
         cap_tx <= {cap_tx[7:0], tx_chk_byte};
      end
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         stop_test();
      end
   end
   // ****************************************
   // tasks
   // ****************************************
   task automatic stop_test();
      $display("tests_run %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [47:0] cw(input logic [1:0] r, input logic v, input logic p,
      input logic [15:0] q, input logic e);
      return {27'h0, r, v, p, q, e};
   endfunction
   task automatic clr();
      @(negedge mclk);
      {n_ok, n_bad, n_cmd, n_rst, n_par, n_rep} = 48'h0;
   endtask
   task automatic rtu(input logic [47:0] f, input logic [15:0] flip, input logic [47:0] e);
      clr();
      mst_u.send_rtu(f, flip);
      repeat (10) @(negedge mclk);
      chk(cnt, e);
   endtask
   task automatic txc(input logic [47:0] f, input logic [15:0] e);
      @(negedge mclk);
      tx_start = 1'h1;
      @(negedge mclk);
      tx_start = 1'h0;
      for (int k = 5; k >= 0; k--) begin
         tx_valid = 1'h1;
         tx_data = f[k*8 +: 8];
         @(negedge mclk);
      end
      tx_valid = 1'h0;
      tx_end = 1'h1;
      @(negedge mclk);
      tx_end = 1'h0;
      repeat (5) @(negedge mclk);
      chk({32'h0, cap_tx}, {32'h0, e});
   endtask
   // ****************************************
   // sequence
   // ****************************************
   initial begin
      {rst, rep_prev} = 2'h2;
      {ascii_mode, tx_start, tx_valid, tx_end, tx_data, cap_tx} = 28'h0;
      repeat (20) @(negedge mclk);
      rst = 1'h0;
      rtu(48'h01_06_20_00_00_12, 16'h0, 48'h01_00_01_00_00_01);
      chk(cmd, cw(RUN_GO, 1'h0, 1'h0, 16'h0, 1'h0));
      rtu(48'h01_06_20_00_ff_61, 16'h0, 48'h01_00_01_00_00_01);
      chk(cmd, cw(RUN_STOP, 1'h1, 1'h1, 16'h0, 1'h0));
      rtu(48'h01_06_20_00_00_30, 16'h0, 48'h01_00_01_00_00_01);
      chk(cmd, cw(RUN_STOP, 1'h0, 1'h0, 16'h0, 1'h0));
      rtu(48'h01_06_20_01_12_34, 16'h0, 48'h01_00_00_00_00_01);
      chk(cmd, cw(RUN_STOP, 1'h0, 1'h0, 16'h1234, 1'h0));
      rtu(48'h01_06_20_02_ff_fd, 16'h0, 48'h01_00_00_00_00_01);
      chk(cmd, cw(RUN_STOP, 1'h0, 1'h0, 16'h1234, 1'h1));
      rtu(48'h01_06_20_02_00_02, 16'h0, 48'h01_00_00_01_00_01);
      chk(cmd, cw(RUN_STOP, 1'h0, 1'h0, 16'h1234, 1'h0));
      rtu(48'h01_06_20_00_00_22, 16'h0100, 48'h00_01_00_00_00_00);
      chk(cmd, cw(RUN_STOP, 1'h0, 1'h0, 16'h1234, 1'h0));
      rtu(48'h00_06_20_00_00_12, 16'h0, 48'h01_00_01_00_00_00);
      chk(cmd, cw(RUN_GO, 1'h0, 1'h0, 16'h1234, 1'h0));
      rtu(48'h02_06_20_00_00_01, 16'h0, 48'h0);
      chk(cmd, cw(RUN_GO, 1'h0, 1'h0, 16'h1234, 1'h0));
      rtu(48'h01_06_04_01_00_07, 16'h0, 48'h01_00_00_00_01_01);
      chk(par_cap, {15'h0, 1'h1, 8'h04, 8'h01, 16'h0007});
      rtu(48'h01_03_04_01_00_01, 16'h0, 48'h01_00_00_00_01_01);
      chk(par_cap[32:16], {1'h0, 8'h04, 8'h01});
      rtu(48'h01_08_00_00_12_34, 16'h0, 48'h01_00_00_00_00_01);
      // slow ack stalls intake so the buffer fills and refuses
      ascii_mode = 1'h1;
      mst_u.ack_dly = 60;
      clr();
      mst_u.send_asc(48'h01_06_04_01_00_09, 8'h00);
      mst_u.send_asc(48'h01_03_04_01_00_01, 8'h00);
      mst_u.send_asc(48'h01_06_04_02_00_05, 8'h00);
      mst_u.send_asc(48'h01_06_04_01_00_09, 8'h01);
      repeat (400) @(negedge mclk);
      chk(cnt, 48'h03_01_00_00_03_03);
      chk(par_cap, {15'h0, 1'h1, 8'h04, 8'h02, 16'h0005});
      chk({47'h0, mst_u.stalls != 0}, 48'h1);
      txc(48'h01_03_04_01_00_01, 16'h4636);
      ascii_mode = 1'h0;
      txc(48'h01_06_01_00_17_70, 16'h8622);
      txc(48'h01_03_21_02_00_02, 16'h6ff7);
      rst = 1'h1;
      repeat (3) @(negedge mclk);
      rst = 1'h0;
      @(negedge mclk);
      chk(cmd, 48'h0);
      stop_test();
   end
endmodule
`default_nettype wire
